// [rtl/qcs_defs.svh]
// register offsets, field positions and reset values for the strobe port
`ifndef QCS_DEFS_SVH
`define QCS_DEFS_SVH

// special function register addresses
`define QCS_ADR_POL     8'hAE
`define QCS_ADR_CTRL_LO 8'hC2
`define QCS_ADR_CTRL_HI 8'hC3
`define QCS_ADR_DATA    8'hD8
`define QCS_ADR_P0_LO   8'h84
`define QCS_ADR_P0_HI   8'h85
`define QCS_ADR_P1_LO   8'h94
`define QCS_ADR_P1_HI   8'h95
`define QCS_ADR_P2_LO   8'hAC
`define QCS_ADR_P2_HI   8'hAD
`define QCS_ADR_P3_LO   8'hB4
`define QCS_ADR_P3_HI   8'hB5

// reset values
`define QCS_RST_CTRL    8'h00
`define QCS_RST_POL     4'h0
`define QCS_RST_DATA    4'hF
`define QCS_RST_BASE    16'h0000

// field layout inside a four-bit per-pin slice
`define QCS_FUN_MSB     3
`define QCS_FUN_LSB     2
`define QCS_CMP_MSB     1
`define QCS_CMP_LSB     0
`define QCS_POL_LSB     4
`define QCS_NPINS       4

// compare masks per compare length
`define QCS_MASK_FULL   16'hFFFF
`define QCS_MASK_A1     16'hFFFE
`define QCS_MASK_A2     16'hFFFC
`define QCS_MASK_A8     16'hFF00

`endif

// [rtl/qcs_pkg.sv]
// types for the quad pin chip-select port
package qcs_pkg;
  typedef enum logic [1:0] {
    QCS_FN_GPIO  = 2'h0,
    QCS_FN_READ  = 2'h1,
    QCS_FN_WRITE = 2'h2,
    QCS_FN_RW    = 2'h3
  } qcs_func_t;

  typedef enum logic [1:0] {
    QCS_CMP_16 = 2'h0,
    QCS_CMP_15 = 2'h1,
    QCS_CMP_14 = 2'h2,
    QCS_CMP_8  = 2'h3
  } qcs_cmp_t;
endpackage

// [rtl/qcs_port.sv]
// quad pin port: general I/O or address-decoded chip-select strobes
// Behaviour
// [R1] function 00: pin is quasi-bidirectional general I/O
// [R2] function 01: pin strobes on matching external data reads
// [R3] function 10: pin strobes on matching external data writes
// [R4] function 11: pin strobes on matching reads or writes
// [R5] compare 00: all sixteen address bits must equal base
// [R6] compare 01: bits 15..1 compared, bit 0 ignored
// [R7] compare 10: bits 15..2 compared, two low bits ignored
// [R8] compare 11: only the upper eight address bits compared
// [R9] high control register: pin3 fields in 7:4, pin2 fields in 3:0
// [R10] low control register: pin1 fields in 7:4, pin0 fields in 3:0
// [R11] polarity bits 7..4 set pins 3..0 high-active; strobe modes only
// [R12] each pin has a 16-bit base from separately written bytes
// [R13] data bits 3..0 drive pins only in general I/O mode; 7..4 reserved
// [R14] polarity clear gives active-low strobe; set gives active-high
// [R15] one matching external write gives exactly one strobe pulse
// [R16] strobes assert and release together with the core read/write strobes
// [R17] reset: data latch ones, control, polarity and bases cleared
// [R18] strobes only on data cycles; leaving strobe mode restores data bit
`timescale 1ns/1ps
`default_nettype none
`include "qcs_defs.svh"

module qcs_port
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // special function register port of the core
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // external data bus cycle from the core
  input  wire logic [15:0] xbus_addr,
  input  wire logic        xbus_rd_n,
  input  wire logic        xbus_wr_n,
  input  wire logic        xbus_data_cycle,
  // port pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe
);

  // reset release: asserted at once, released through two flops
  logic        rst_meta_n;
  logic        rst_n;

  // one-cycle write decodes, one per register group
  logic        wr_ctrl_lo;
  logic        wr_ctrl_hi;
  logic        wr_pol;
  logic        wr_data;
  logic [3:0]  sfr_base_lo_sel;
  logic [3:0]  sfr_base_hi_sel;

  // programmed state
  logic [7:0]  ctrl_lo;
  logic [7:0]  ctrl_hi;
  logic [3:0]  strobe_pol;
  logic [3:0]  port_data;
  logic [7:0]  base_lo [0:3];
  logic [7:0]  base_hi [0:3];

  // core cycle qualifiers, common to every pin
  logic        rd_act;
  logic        wr_act;

  // per-pin results gathered into vectors
  logic [3:0]  pin_strobe_mode;
  logic [3:0]  next_pin_out;

  // address window for a compare length
  function automatic logic [15:0] qcs_mask(input logic [1:0] len);
    logic [15:0] m;
    m = `QCS_MASK_FULL;
    unique case (qcs_pkg::qcs_cmp_t'(len))
      qcs_pkg::QCS_CMP_16: m = `QCS_MASK_FULL; // R5
      qcs_pkg::QCS_CMP_15: m = `QCS_MASK_A1;   // R6
      qcs_pkg::QCS_CMP_14: m = `QCS_MASK_A2;   // R7
      qcs_pkg::QCS_CMP_8:  m = `QCS_MASK_A8;   // R8
    endcase
    return m;
  endfunction

  // address decode of the base byte registers, shared by write and read
  function automatic logic [1:0] qcs_base_idx(input logic [7:0] a);
    logic [1:0] i;
    i = 2'h0;
    unique case (a)
      `QCS_ADR_P0_LO, `QCS_ADR_P0_HI: i = 2'h0;
      `QCS_ADR_P1_LO, `QCS_ADR_P1_HI: i = 2'h1;
      `QCS_ADR_P2_LO, `QCS_ADR_P2_HI: i = 2'h2;
      `QCS_ADR_P3_LO, `QCS_ADR_P3_HI: i = 2'h3;
      default:                        i = 2'h0;
    endcase
    return i;
  endfunction

  // does a pin in this function fire for the current core cycle
  function automatic logic qcs_fire(input logic [1:0] fn,
                                    input logic       rd,
                                    input logic       wr);
    logic f;
    f = 1'b0;
    unique case (qcs_pkg::qcs_func_t'(fn))
      qcs_pkg::QCS_FN_GPIO:  f = 1'b0;     // R1
      qcs_pkg::QCS_FN_READ:  f = rd;       // R2
      qcs_pkg::QCS_FN_WRITE: f = wr;       // R3 R15
      qcs_pkg::QCS_FN_RW:    f = rd || wr; // R4
    endcase
    return f;
  endfunction

  // reset release through two flops so deassertion is clean
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // write strobes per register; unmapped addresses match none of them
  assign wr_ctrl_lo = sfr_wr && (sfr_addr == `QCS_ADR_CTRL_LO);
  assign wr_ctrl_hi = sfr_wr && (sfr_addr == `QCS_ADR_CTRL_HI);
  assign wr_pol     = sfr_wr && (sfr_addr == `QCS_ADR_POL);
  assign wr_data    = sfr_wr && (sfr_addr == `QCS_ADR_DATA);

  // low control register: pins 1 and 0
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_lo <= `QCS_RST_CTRL; // R17
    else if (wr_ctrl_lo)
      ctrl_lo <= sfr_wdata; // R10
  end

  // high control register: pins 3 and 2
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_hi <= `QCS_RST_CTRL; // R17
    else if (wr_ctrl_hi)
      ctrl_hi <= sfr_wdata; // R9
  end

  // polarity nibble; the low half of the byte is reserved, reads 0
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_pol <= `QCS_RST_POL; // R14 R17
    else if (wr_pol)
      strobe_pol <= sfr_wdata[7:`QCS_POL_LSB]; // R11
  end

  // port data latch, upper four bits reserved
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      port_data <= `QCS_RST_DATA; // R17
    else if (wr_data)
      port_data <= sfr_wdata[3:0]; // R13
  end

  // fetches never strobe; only data cycles of the core qualify
  assign rd_act = xbus_data_cycle && !xbus_rd_n; // R18
  assign wr_act = xbus_data_cycle && !xbus_wr_n; // R18

  // one-hot selects for the base byte registers
  always_comb
  begin
    sfr_base_lo_sel = 4'h0;
    sfr_base_hi_sel = 4'h0;
    unique case (sfr_addr)
      `QCS_ADR_P0_LO, `QCS_ADR_P1_LO, `QCS_ADR_P2_LO, `QCS_ADR_P3_LO:
        sfr_base_lo_sel[qcs_base_idx(sfr_addr)] = 1'b1;
      `QCS_ADR_P0_HI, `QCS_ADR_P1_HI, `QCS_ADR_P2_HI, `QCS_ADR_P3_HI:
        sfr_base_hi_sel[qcs_base_idx(sfr_addr)] = 1'b1;
      default:
      begin
        sfr_base_lo_sel = 4'h0;
        sfr_base_hi_sel = 4'h0;
      end
    endcase
  end

  // per pin: field slice, base address, masked compare, output mux.
  // the whole path from bus inputs to pin is combinational so the
  // strobe edges follow the core strobes with no added latency
  genvar g;
  generate
    for (g = 0; g < `QCS_NPINS; g = g + 1)
    begin : g_pin
      logic [3:0]  fields;
      logic [1:0]  func;
      logic [15:0] mask;
      logic [15:0] base;
      logic        hit_addr;
      logic        hit;

      // pins 3,2 live in the high register, pins 1,0 in the low one
      if (g >= 2)
      begin : g_hi
        assign fields = (g == 3) ? ctrl_hi[7:4] : ctrl_hi[3:0]; // R9
      end
      else
      begin : g_lo
        assign fields = (g == 1) ? ctrl_lo[7:4] : ctrl_lo[3:0]; // R10
      end

      // low base byte; the two bytes are written separately, so a
      // half-updated base can match briefly: reprogram in I/O mode
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          base_lo[g] <= 8'(`QCS_RST_BASE); // R17
        else if (sfr_wr && sfr_base_lo_sel[g])
          base_lo[g] <= sfr_wdata; // R12
      end

      // high base byte
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          base_hi[g] <= 8'(`QCS_RST_BASE >> 8); // R17
        else if (sfr_wr && sfr_base_hi_sel[g])
          base_hi[g] <= sfr_wdata; // R12
      end

      // masked compare; masked-off bits never block a match
      assign func     = fields[`QCS_FUN_MSB:`QCS_FUN_LSB];
      assign mask     = qcs_mask(fields[`QCS_CMP_MSB:`QCS_CMP_LSB]);
      assign base     = {base_hi[g], base_lo[g]}; // R12
      assign hit_addr = ((xbus_addr ^ base) & mask) == 16'h0000;
      assign hit      = hit_addr && qcs_fire(func, rd_act, wr_act);

      // any function other than general I/O makes the pin a strobe
      assign pin_strobe_mode[g] =
        (qcs_pkg::qcs_func_t'(func) != qcs_pkg::QCS_FN_GPIO); // R1

      // strobe level or data bit; an idle strobe sits at its off level
      always_comb
      begin
        if (pin_strobe_mode[g])
          next_pin_out[g] = hit ~^ strobe_pol[g]; // R11 R14
        else
          next_pin_out[g] = port_data[g]; // R13 R18
      end
    end
  endgenerate

  // pins follow the core strobes combinationally so edges line up;
  // a register here would lag the peripheral select by one cycle
  assign pin_out = next_pin_out; // R16

  // quasi-bidirectional: drive low hard, strobes drive both levels,
  // a one in I/O mode is left to the pull-up so the pin can be read
  always_comb
  begin
    pin_oe = pin_strobe_mode | ~port_data; // R1
  end

  // register read back; I/O pins report the pin level, not the latch,
  // so software sees a pin held low from outside even with a one set.
  // reserved bits and unmapped addresses read as zero
  always_comb
  begin
    sfr_rdata = 8'h00;
    unique case (sfr_addr)
      `QCS_ADR_CTRL_LO: sfr_rdata = ctrl_lo;
      `QCS_ADR_CTRL_HI: sfr_rdata = ctrl_hi;
      `QCS_ADR_POL:     sfr_rdata = {strobe_pol, 4'h0};
      `QCS_ADR_DATA:    sfr_rdata = {4'h0, pin_in};
      `QCS_ADR_P0_LO, `QCS_ADR_P1_LO, `QCS_ADR_P2_LO, `QCS_ADR_P3_LO:
        sfr_rdata = base_lo[qcs_base_idx(sfr_addr)];
      `QCS_ADR_P0_HI, `QCS_ADR_P1_HI, `QCS_ADR_P2_HI, `QCS_ADR_P3_HI:
        sfr_rdata = base_hi[qcs_base_idx(sfr_addr)];
      default:          sfr_rdata = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// [bench/qcs_port_checker.sv]
// assertions on the chip-select port registers and pins
`timescale 1ns/1ps
`default_nettype none
module qcs_port_checker
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // register port
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // external bus
  input wire logic [15:0] xbus_addr,
  input wire logic        xbus_rd_n,
  input wire logic        xbus_wr_n,
  input wire logic        xbus_data_cycle,
  // pins
  input wire logic [3:0]  pin_in,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe
);
  logic [15:0] ctl;
  logic [3:0]  pol;
  logic [3:0]  dat;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // shadow latches; bench never writes inside the reset sync window
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl <= 16'h0000;
      pol <= 4'h0;
      dat <= 4'hF;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        8'hC2: ctl[7:0] <= sfr_wdata;
        8'hC3: ctl[15:8] <= sfr_wdata;
        8'hAE: pol <= sfr_wdata[7:4];
        8'hD8: dat <= sfr_wdata[3:0];
        default: ;
      endcase
    end
  end
  rst_idle_a: assert property ($rose(arst_n) |->
    pin_out == 4'hF && !pin_oe)
    else $error("pins not idle after reset");
  ctrl_lo_a: assert property (sfr_wr && sfr_addr == 8'hC2 ##1
    sfr_addr == 8'hC2 |-> sfr_rdata == $past(sfr_wdata))
    else $error("low control readback wrong");
  ctrl_hi_a: assert property (sfr_addr == 8'hC3 |->
    sfr_rdata == ctl[15:8])
    else $error("high control readback wrong");
  pol_read_a: assert property (sfr_addr == 8'hAE |->
    sfr_rdata == {pol, 4'h0})
    else $error("polarity readback wrong");
  // per pin: field slice is ctl[4i+3:4i]
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    gpio_drive_a: assert property (ctl[4*i+3 -: 2] == 2'h0 |->
      pin_out[i] == dat[i] && pin_oe[i] == !dat[i])
      else $error("general pin drive wrong");
    fetch_quiet_a: assert property (ctl[4*i+3 -: 2] != 2'h0 &&
      !xbus_data_cycle |-> pin_out[i] == !pol[i] && pin_oe[i])
      else $error("strobe outside data cycle");
    read_only_a: assert property (ctl[4*i+3 -: 2] == 2'h1 &&
      xbus_rd_n |-> pin_out[i] == !pol[i])
      else $error("read strobe without read");
    write_only_a: assert property (ctl[4*i+3 -: 2] == 2'h2 &&
      xbus_wr_n |-> pin_out[i] == !pol[i])
      else $error("write strobe without write");
  end
endmodule
`default_nettype wire

// [bench/qcs_periph.sv]
// far side: chips on pulled-up port pins
`timescale 1ns/1ps
`default_nettype none
module qcs_periph
(
  // port pins
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // resolved wire level
  output logic      [3:0] pin_lvl
);
  // released pins float up to the pull-up level
  assign pin_lvl = pin_out | ~pin_oe;
endmodule
`default_nettype wire

// [bench/test_qcs_port.sv]
// self-checking bench for the quad chip-select port
`timescale 1ns/1ps
`default_nettype none
module test_qcs_port;
  logic        mclk, arst_n, sfr_wr, rd_n, wr_n, dc;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] xa;
  logic [3:0]  lvl, pout, poe;
  int          mismatches, n_checks, pulses, p;
  // register writes: address byte then data byte
  logic [15:0] cfg [11] = '{16'hC25A, 16'hC34F, 16'hAE90, 16'h8434,
    16'h8512, 16'h9478, 16'h9556, 16'hAC00, 16'hADAB, 16'hB4FF, 16'hB500};
  // bus cycle: address, data cycle, rd_n, wr_n; expected pins
  logic [22:0] rows [11] = '{{16'h1237, 3'h6, 4'h7}, {16'h1238, 3'h6, 4'h6},
    {16'h1234, 3'h2, 4'h6}, {16'h5679, 3'h5, 4'h4}, {16'h567A, 3'h5, 4'h6},
    {16'h5679, 3'h6, 4'h6}, {16'hABCD, 3'h6, 4'h2}, {16'hAB12, 3'h5, 4'h2},
    {16'h00FF, 3'h5, 4'hE}, {16'h00FE, 3'h5, 4'h6}, {16'h1234, 3'h5, 4'h6}};
  qcs_port dut_u (.mclk(mclk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .xbus_addr(xa), .xbus_rd_n(rd_n), .xbus_wr_n(wr_n),
    .xbus_data_cycle(dc), .pin_in(lvl), .pin_out(pout), .pin_oe(poe));
  qcs_periph far_u (.pin_out(pout), .pin_oe(poe), .pin_lvl(lvl));
  // counts chip-select pulses seen on pin 0
  always @(posedge lvl[0])
    pulses++;
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] aw);
    @(negedge mclk);
    {sfr_addr, sfr_wdata} = aw;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    sfr_addr = a;
    #1;
  endtask
  task automatic cyc(input logic [18:0] c);
    @(negedge mclk);
    {xa, dc, rd_n, wr_n} = c;
    #1;
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run is about 1 us
  initial
  begin
    #20000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    {arst_n, sfr_wr, sfr_addr, sfr_wdata} = 18'h0;
    {xa, dc, rd_n, wr_n} = 19'h00003;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("pin_out", 16'(pout), 16'h000F);
    foreach (cfg[i])
    begin
      rd(cfg[i][15:8]);
      chk("sfr_rdata", 16'(sfr_rdata), 16'h0000);
    end
    rd(8'h80);
    chk("unmapped", 16'(sfr_rdata), 16'h0000);
    foreach (cfg[i])
      wr(cfg[i]);
    foreach (cfg[i])
    begin
      rd(cfg[i][15:8]);
      chk("sfr_rdata", 16'(sfr_rdata), 16'(cfg[i][7:0]));
    end
    foreach (rows[i])
    begin
      cyc(rows[i][22:4]);
      chk("pins", 16'(pout), 16'(rows[i][3:0]));
      cyc(19'h00003);
      chk("pin_out", 16'(pout), 16'h0006);
    end
    p = pulses;
    cyc({16'h1235, 3'h6});
    @(negedge mclk);
    cyc(19'h00003);
    chk("pulses", 16'(pulses - p), 16'h0001);
    wr(16'hC30F);
    wr(16'hD8F5);
    chk("pin_out", 16'(pout), 16'h0006);
    rd(8'hD8);
    chk("pin_in", 16'(sfr_rdata), 16'h0006);
    @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    arst_n = 1'b1;
    rd(8'hC2);
    chk("after reset", 16'(sfr_rdata), 16'h0000);
    end_of_test();
  end
endmodule
bind qcs_port qcs_port_checker chk_u (.mclk(mclk), .arst_n(arst_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .xbus_addr(xbus_addr), .xbus_rd_n(xbus_rd_n),
  .xbus_wr_n(xbus_wr_n), .xbus_data_cycle(xbus_data_cycle),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
